// ==== design/nsc_stack_ctrl.sv ====
// Function
// - 8-bit pointer at two peripheral nibbles; 8-bit accesses only.
// - Pointer bit 0 is forced to zero; software writes zero there.
// - Push decrements, pop increments, pointer marks last written entry.
// - Stack accesses always go to bank 0, ignoring bank flags.
// - Register push writes two nibbles below pointer, then pointer minus two.
// - Call stores PC and bank enable flags in six nibbles, pointer minus six.
// - Interrupt entry saves PC and status word, pointer minus six.
// - Register pop restores lower then upper nibble, pointer plus two.
// - Returns reload PC and bank enable flags, pointer plus six.
// - Interrupt return reloads PC and status word, pointer plus six.
// - With register bank enable 0, bank select leaves bank 0 active.
// - With register bank enable 1, bank select operand picks active bank.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module nsc_stack_ctrl
    import nsc_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    // Register port (8-bit transfers only)
    input  wire logic [11:0] i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    output logic      [7:0]  o_reg_rdata,
    // Sequencer request
    input  wire logic        i_op_valid,
    input  wire logic [2:0]  i_op,
    input  wire logic [7:0]  i_pair_data,
    input  wire nsc_ctx_s    i_ctx,
    output logic             o_busy,
    output logic             o_done,
    output logic      [7:0]  o_pair_data,
    output nsc_ctx_s         o_ctx,
    // Register bank select
    input  wire logic        i_rb_sel_valid,
    input  wire logic [1:0]  i_rb_sel,
    input  wire logic        i_reg_bank_en,
    output logic      [1:0]  o_active_rb,
    // Stack memory, bank 0
    output nsc_mem_s         o_mem,
    input  wire logic [3:0]  i_mem_rdata,
    // Pointer view
    output logic      [7:0]  o_stack_pointer
);

    function automatic logic [7:0] sp_add(input logic [7:0] a,
                                          input logic [7:0] b);
        sp_add = a + b;
    endfunction

    function automatic logic [3:0] nib(input logic [23:0] w,
                                       input logic [2:0]  i);
        nib = w[{i, 2'b00} +: 4];
    endfunction

    nsc_state_e  state_reg, state_next;
    logic [7:0]  sp_reg, sp_next;
    logic [2:0]  cnt_reg, cnt_next;
    logic [2:0]  last_reg, last_next;
    nsc_op_e     op_reg, op_next;
    logic [23:0] buf_reg, buf_next;
    logic        done_reg, done_next;
    logic        rd_pend_reg;
    logic [2:0]  rd_idx_reg;
    logic [7:0]  rdata_reg, rdata_next;
    nsc_mem_s    mem_reg, mem_next;
    logic [1:0]  rb_reg, rb_next;
    logic [7:0]  pair_out_reg, pair_out_next;
    nsc_ctx_s    ctx_out_reg, ctx_out_next;
    logic        busy_reg;

    // Decode
    wire        sp_hit   = (i_reg_addr == NSC_SP_LO_ADDR);
    wire        sp_wr    = i_reg_wr && sp_hit;
    wire        idle     = (state_reg == NSC_ST_IDLE);
    wire        go       = i_op_valid && idle;
    wire        is_pair  = (i_op == NSC_OP_PUSH) || (i_op == NSC_OP_POP);
    wire        is_push  = (i_op == NSC_OP_PUSH) || (i_op == NSC_OP_CALL)
                           || (i_op == NSC_OP_INT);
    wire        is_pop   = (i_op == NSC_OP_POP) || (i_op == NSC_OP_RET)
                           || (i_op == NSC_OP_INTERRUPT_RETURN);
    wire [23:0] ctx_word = {i_ctx.pc, i_ctx.program_status_word, 2'b00,
                            i_ctx.mem_bank_en, i_ctx.reg_bank_en};
    wire [23:0] src_word = is_pair ? {16'h0000, i_pair_data} : ctx_word;
    wire        cnt_last = (cnt_reg == last_reg);
    // Push walks down from sp-1, top nibble first, so the
    // lowest nibble ends at the new pointer and pops first
    wire [7:0]  push_ofs = sp_add(sp_reg, ~{5'h00, cnt_reg});
    wire [2:0]  push_idx = last_reg - cnt_reg;
    wire [7:0]  pop_ofs  = sp_add(sp_reg, {5'h00, cnt_reg});
    wire [7:0]  frame    = (last_reg == NSC_PAIR_LAST) ? NSC_PAIR_NIBBLES
                                                        : NSC_FRAME_NIBBLES;
    wire [23:0] rd_word  = buf_reg | ({20'h0_0000, i_mem_rdata}
                                      << {rd_idx_reg, 2'b00});
    // Shared next values
    wire        pop_land = rd_pend_reg && idle && !mem_reg.rd;
    wire [7:0]  sp_down  = sp_add(sp_reg, ~frame + 8'h01);
    wire [7:0]  sp_up    = sp_add(sp_reg, frame);
    wire [7:0]  sp_view  = sp_hit ? sp_reg : 8'h00;
    wire [1:0]  rb_pick  = i_reg_bank_en ? i_rb_sel : NSC_RB_ZERO;

    always_comb begin
        state_next    = state_reg;
        sp_next       = sp_reg;
        cnt_next      = cnt_reg;
        last_next     = last_reg;
        op_next       = op_reg;
        buf_next      = rd_pend_reg ? rd_word : buf_reg;
        done_next     = 1'b0;
        rdata_next    = rdata_reg;
        mem_next      = '0;
        rb_next       = rb_reg;
        pair_out_next = pair_out_reg;
        ctx_out_next  = ctx_out_reg;

        if (i_reg_rd) begin
            rdata_next = sp_view;
        end
        if (i_rb_sel_valid) begin
            rb_next = rb_pick;
        end

        case (state_reg)
            NSC_ST_IDLE: begin
                if (sp_wr) begin
                    sp_next = {i_reg_wdata[7:1], 1'b0};
                end else if (go && is_push) begin
                    state_next = NSC_ST_PUSH;
                    op_next    = nsc_op_e'(i_op);
                    cnt_next   = 3'h0;
                    last_next  = is_pair ? NSC_PAIR_LAST
                                         : NSC_FRAME_LAST;
                    buf_next   = src_word;
                end else if (go && is_pop) begin
                    state_next = NSC_ST_POP;
                    op_next    = nsc_op_e'(i_op);
                    cnt_next   = 3'h0;
                    last_next  = is_pair ? NSC_PAIR_LAST
                                         : NSC_FRAME_LAST;
                    buf_next   = 24'h00_0000;
                end
            end
            NSC_ST_PUSH: begin
                mem_next.wr    = 1'b1;
                mem_next.addr  = {NSC_STACK_BANK, push_ofs};
                mem_next.wdata = nib(buf_reg, push_idx);
                cnt_next       = cnt_reg + 3'h1;
                if (cnt_last) begin
                    sp_next    = sp_down;
                    state_next = NSC_ST_IDLE;
                    done_next  = 1'b1;
                end
            end
            NSC_ST_POP: begin
                // Lower nibble read first
                mem_next.rd   = 1'b1;
                mem_next.addr = {NSC_STACK_BANK, pop_ofs};
                cnt_next      = cnt_reg + 3'h1;
                if (cnt_last) begin
                    sp_next    = sp_up;
                    state_next = NSC_ST_IDLE;
                end
            end
            default: begin
                state_next = NSC_ST_IDLE;
            end
        endcase

        // Last read data lands one cycle after the final strobe
        if (pop_land) begin
            done_next = 1'b1;
            if (op_reg == NSC_OP_POP) begin
                pair_out_next = rd_word[7:0];
            end else begin
                ctx_out_next.pc          = rd_word[23:12];
                ctx_out_next.program_status_word         = rd_word[11:4];
                ctx_out_next.mem_bank_en = rd_word[1];
                ctx_out_next.reg_bank_en = rd_word[0];
            end
        end
    end

    // Sequencer state
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= NSC_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            cnt_reg  <= 3'h0;
            last_reg <= 3'h0;
        end else begin
            cnt_reg  <= cnt_next;
            last_reg <= last_next;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            op_reg <= NSC_OP_NONE;
        end else begin
            op_reg <= op_next;
        end
    end

    // Busy kept in a flop so the output carries no decode glitch
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= (state_next != NSC_ST_IDLE);
        end
    end

    // Pointer has no meaningful reset; zero only for determinism
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            sp_reg <= NSC_SP_RESET;
        end else begin
            sp_reg <= sp_next;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            buf_reg <= 24'h00_0000;
        end else begin
            buf_reg <= buf_next;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rd_pend_reg <= 1'b0;
            rd_idx_reg  <= 3'h0;
        end else begin
            rd_pend_reg <= mem_reg.rd;
            rd_idx_reg  <= cnt_reg - 3'h1;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            mem_reg <= '0;
        end else begin
            mem_reg <= mem_next;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // Bank select takes effect on the next cycle
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rb_reg <= NSC_RB_ZERO;
        end else begin
            rb_reg <= rb_next;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= done_next;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pair_out_reg <= 8'h00;
            ctx_out_reg  <= '0;
        end else begin
            pair_out_reg <= pair_out_next;
            ctx_out_reg  <= ctx_out_next;
        end
    end

    assign o_reg_rdata     = rdata_reg;
    assign o_busy          = busy_reg;
    assign o_done          = done_reg;
    assign o_pair_data     = pair_out_reg;
    assign o_ctx           = ctx_out_reg;
    assign o_active_rb     = rb_reg;
    assign o_mem           = mem_reg;
    assign o_stack_pointer = sp_reg;

endmodule

// ==== include/nsc_pkg.sv ====
package nsc_pkg;

    // Register map
    localparam logic [11:0] NSC_SP_LO_ADDR   = 12'h0f80;
    localparam logic [11:0] NSC_SP_HI_ADDR   = 12'h0f81;
    localparam logic [7:0]  NSC_SP_RESET     = 8'h00;

    // Frame sizes in nibbles
    localparam logic [7:0]  NSC_PAIR_NIBBLES  = 8'h02;
    localparam logic [7:0]  NSC_FRAME_NIBBLES = 8'h06;
    localparam logic [2:0]  NSC_PAIR_LAST     = 3'h1;
    localparam logic [2:0]  NSC_FRAME_LAST    = 3'h5;

    // Stack lives in bank 0
    localparam logic [3:0]  NSC_STACK_BANK   = 4'h0;
    localparam logic [1:0]  NSC_RB_ZERO      = 2'h0;

    typedef enum logic [2:0] {
        NSC_OP_NONE  = 3'b000,
        NSC_OP_PUSH  = 3'b001,
        NSC_OP_CALL  = 3'b010,
        NSC_OP_INT   = 3'b011,
        NSC_OP_POP   = 3'b100,
        NSC_OP_RET   = 3'b101,
        NSC_OP_INTERRUPT_RETURN  = 3'b110
    } nsc_op_e;

    typedef enum logic [1:0] {
        NSC_ST_IDLE  = 2'b00,
        NSC_ST_PUSH  = 2'b01,
        NSC_ST_POP   = 2'b10
    } nsc_state_e;

    // Memory access to the stack
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [3:0]  wdata;
    } nsc_mem_s;

    // Saved context, 22 bits, padded to six nibbles on the stack
    typedef struct packed {
        logic [11:0] pc;
        logic [7:0]  program_status_word;
        logic        mem_bank_en;
        logic        reg_bank_en;
    } nsc_ctx_s;

endpackage

// ==== bench/nsc_stack_asserts.sv ====
`timescale 1ns/1ps
module nsc_stack_asserts
    import nsc_pkg::*;
(
    // Clock, reset, register port
    input wire logic        i_clk,
    input wire logic        i_reset,
    input wire logic [11:0] i_reg_addr,
    input wire logic [7:0]  i_reg_wdata,
    input wire logic        i_reg_wr,
    // Sequencer, banks, memory, pointer
    input wire logic        i_op_valid,
    input wire logic [2:0]  i_op,
    input wire logic [7:0]  i_pair_data,
    input wire logic        o_busy,
    input wire logic        o_done,
    input wire logic        i_rb_sel_valid,
    input wire logic [1:0]  i_rb_sel,
    input wire logic        i_reg_bank_en,
    input wire logic [1:0]  o_active_rb,
    input wire nsc_mem_s    o_mem,
    input wire logic [7:0]  o_stack_pointer
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // A pointer write in the same cycle drops the op
    wire sp_sel = i_reg_addr == NSC_SP_LO_ADDR;
    wire take = i_op_valid && !o_busy && !(i_reg_wr && sp_sel);
    property p_order;
        logic [7:0] s, d;
        (take && i_op == NSC_OP_PUSH, s = o_stack_pointer, d = i_pair_data)
        |-> ##2 o_mem.wr && o_mem.addr[7:0] == s - 8'h01
        && o_mem.wdata == d[7:4]
        ##1 o_mem.wr && o_mem.addr[7:0] == s - 8'h02 && o_mem.wdata == d[3:0];
    endproperty
    a_sp_even: assert property (o_stack_pointer[0] == 1'b0)
        else $error("pointer bit 0 set");
    a_stack_bank: assert property (o_mem.wr || o_mem.rd |->
        o_mem.addr[11:8] == NSC_STACK_BANK) else $error("bank not 0");
    a_push_order: assert property (p_order)
        else $error("push nibble order");
    a_pair_push: assert property (take && i_op == NSC_OP_PUSH |-> ##3
        o_done && o_stack_pointer == $past(o_stack_pointer, 3) - 8'h02)
        else $error("pair push step");
    a_frame_push: assert property (take && (i_op == NSC_OP_CALL ||
        i_op == NSC_OP_INT) |-> ##7 o_done &&
        o_stack_pointer == $past(o_stack_pointer, 7) - 8'h06)
        else $error("frame push step");
    a_pair_pop: assert property (take && i_op == NSC_OP_POP |-> ##5
        o_done && o_stack_pointer == $past(o_stack_pointer, 5) + 8'h02)
        else $error("pair pop step");
    a_frame_pop: assert property (take && (i_op == NSC_OP_RET ||
        i_op == NSC_OP_INTERRUPT_RETURN) |-> ##9 o_done &&
        o_stack_pointer == $past(o_stack_pointer, 9) + 8'h06)
        else $error("frame pop step");
    a_bank_off: assert property (i_rb_sel_valid && !i_reg_bank_en |=>
        o_active_rb == NSC_RB_ZERO) else $error("bank not 0");
    a_bank_on: assert property (i_rb_sel_valid && i_reg_bank_en |=>
        o_active_rb == $past(i_rb_sel)) else $error("bank select lost");
    a_sp_load: assert property (i_reg_wr && sp_sel && !o_busy |=>
        o_stack_pointer == ($past(i_reg_wdata) & 8'hfe))
        else $error("pointer load");
    a_busy_frame: assert property (take && i_op == NSC_OP_INT |=>
        o_busy [*6] ##1 !o_busy) else $error("busy span");
    c_int: cover property (take && i_op == NSC_OP_INT);
    c_pop: cover property (take && i_op == NSC_OP_POP);
    c_bank: cover property (i_rb_sel_valid && i_reg_bank_en);
endmodule
bind nsc_stack_ctrl nsc_stack_asserts u_chk (.*);

// ==== bench/nsc_stack_mem.sv ====
`timescale 1ns/1ps
module nsc_stack_mem
    import nsc_pkg::*;
(
    // Clock and access
    input  wire logic     i_clk,
    input  wire nsc_mem_s i_mem,
    // Read data, one cycle after the strobe
    output logic [3:0]    o_rdata
);
    logic [3:0] mem [256];
    // Idle cycles toggle the data so a stale nibble never looks valid
    initial o_rdata = 4'h0;
    always @(posedge i_clk) begin
        if (i_mem.wr) mem[i_mem.addr[7:0]] <= i_mem.wdata;
        if (i_mem.rd) o_rdata <= mem[i_mem.addr[7:0]];
        else o_rdata <= ~o_rdata;
    end
endmodule

// ==== bench/test_nibble_stack_control.sv ====
`timescale 1ns/1ps
module test_nibble_stack_control;
    import nsc_pkg::*;
    localparam logic [21:0] CTX_INT  = 22'h2d_9c5b;
    localparam logic [21:0] CTX_CALL = 22'h16_a3e6;
    logic        i_clk = 1'b0, i_reset = 1'b1, i_reg_wr = 1'b0;
    logic        i_reg_rd = 1'b0, i_op_valid = 1'b0, i_rb_sel_valid = 1'b0;
    logic        i_reg_bank_en = 1'b0, o_busy, o_done;
    logic [11:0] i_reg_addr = 12'h000;
    logic [7:0]  i_reg_wdata = 8'h00, i_pair_data = 8'h00;
    logic [7:0]  o_reg_rdata, o_pair_data, o_stack_pointer;
    logic [2:0]  i_op = 3'h0;
    logic [1:0]  i_rb_sel = 2'h0, o_active_rb;
    logic [3:0]  i_mem_rdata;
    nsc_ctx_s    i_ctx = '0, o_ctx;
    nsc_mem_s    o_mem;
    int          n_mismatch = 0, num_checks = 0;
    initial forever #12.5 i_clk = ~i_clk;
    nsc_stack_ctrl i_dut (.*);
    nsc_stack_mem u_mem (.i_clk(i_clk), .i_mem(o_mem), .o_rdata(i_mem_rdata));
    task chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_clk);
        i_reg_rd <= 1'b0;
        #1 chk(o_reg_rdata, e);
    endtask
    // Pair data rides in the low byte of the context word
    task op(input logic [2:0] c, input logic [21:0] x, input logic [7:0] sp);
        int k;
        @(posedge i_clk);
        i_op <= c;
        i_ctx <= x;
        i_pair_data <= x[7:0];
        i_op_valid <= 1'b1;
        @(posedge i_clk);
        i_op_valid <= 1'b0;
        for (k = 0; k < 12; k++) begin
            #1 if (o_done === 1'b1) break;
            @(posedge i_clk);
        end
        if (k == 12) begin
            n_mismatch++;
            end_of_test;
        end
        chk(o_stack_pointer, sp);
    endtask
    initial begin
        repeat (3) @(posedge i_clk);
        i_reset <= 1'b0;
        wr(NSC_SP_LO_ADDR, 8'h37);
        rd(NSC_SP_LO_ADDR, 8'h36);
        rd(12'hf82, 8'h00);
        wr(NSC_SP_LO_ADDR, 8'h00);
        $display("test registers done");
        op(NSC_OP_INT, CTX_INT, 8'hfa);
        chk(u_mem.mem[8'hff], CTX_INT[21:18]);
        op(NSC_OP_PUSH, 22'h00_00a5, 8'hf8);
        @(posedge i_clk);
        #1 chk(u_mem.mem[8'hf9], 4'ha);
        chk(u_mem.mem[8'hf8], 4'h5);
        op(NSC_OP_CALL, CTX_CALL, 8'hf2);
        op(NSC_OP_RET, 22'h00_0000, 8'hf8);
        chk({o_ctx.pc, o_ctx[1:0]}, {CTX_CALL[21:10], CTX_CALL[1:0]});
        op(NSC_OP_POP, 22'h00_0000, 8'hfa);
        chk(o_pair_data, 8'ha5);
        op(NSC_OP_INTERRUPT_RETURN, 22'h00_0000, 8'h00);
        chk(o_ctx, CTX_INT);
        $display("test stack done");
        for (int e = 1; e >= 0; e--) begin
            @(posedge i_clk);
            i_reg_bank_en <= e[0];
            i_rb_sel <= 2'h2;
            i_rb_sel_valid <= 1'b1;
            @(posedge i_clk);
            i_rb_sel_valid <= 1'b0;
            #1 chk(o_active_rb, e ? 2'h2 : 2'h0);
        end
        $display("test banks done");
        end_of_test;
    end
endmodule
